/* pkg/acr_map.vh */
`ifndef ACR_MAP_VH
`define ACR_MAP_VH
`define ACR_ADDR_MUX       8'hD7
`define ACR_ADDR_IRQ       8'hD8
`define ACR_ADDR_RES_LO    8'hD9
`define ACR_ADDR_RES_MID   8'hDA
`define ACR_ADDR_RES_HI    8'hDB
`define ACR_ADDR_AFC       8'hDC
`define ACR_ADDR_CFC       8'hDD
`define ACR_RST_MUX        8'h01
`define ACR_RST_IRQ        8'h40
`define ACR_RST_AFC        8'h30
`define ACR_RST_CFC        8'h00
`define ACR_MUX_TEMP       8'hFF
`define ACR_NEG_COMMON     4'h8
`define ACR_BIT_BAUD2      7
`define ACR_BIT_AUX_EN     5
`define ACR_BIT_AUX_FLAG   4
`define ACR_BIT_WDT_FLAG   3
`define ACR_BIT_BURNOUT    6
`define ACR_BIT_REF_EN     5
`define ACR_BIT_REF_LVL    4
`define ACR_BIT_BUF_EN     3
`define ACR_BIT_POL        6
`define ACR_CAL_RESERVED   3'h6
`endif

/* sim/acr_regs_chk.sv */
`timescale 1ns/1ps
module acr_regs_chk (
  input wire       ref_clk,          // clock
  input wire       rstn,             // reset
  input wire [7:0] sfr_addr,         // address
  input wire       sfr_wr,           // write
  input wire       sfr_rd,           // read
  input wire       conv_done,        // sample in
  input wire       watchdog_event,   // expiry
  input wire       wdt_reset_enable, // reset action
  input wire       watchdog_reset,   // reset out
  input wire       data_irq,         // data irq
  input wire       watchdog_irq,     // wdt irq
  input wire [8:0] neg_input_onehot, // neg decode
  input wire       temp_sensor_on,   // sensor
  input wire [7:0] input_mux_reg     // mux reg
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence low_read; sfr_rd && sfr_addr == 8'hD9 && !conv_done; endsequence
  rd_low_clr_a: assert property (low_read |=> !data_irq) else $error("low read kept irq");
  mid_keep_a: assert property (data_irq && sfr_rd && sfr_addr[7:1] == 7'h6D |=> data_irq) else $error("irq lost");
  conv_irq_a: assert property (conv_done |=> data_irq) else $error("no data irq");
  neg_decode_a: assert property (input_mux_reg[3:0] <= 4'h8 |-> neg_input_onehot == 9'h001 << input_mux_reg[3:0])
    else $error("neg decode");
  temp_sense_a: assert property (temp_sensor_on == (input_mux_reg == 8'hFF)) else $error("temp sensor");
  wdt_block_a: assert property (wdt_reset_enable |-> !watchdog_irq) else $error("wdt irq in reset mode");
  wdt_reset_a: assert property (watchdog_reset == (watchdog_event && wdt_reset_enable)) else $error("wdt reset");
  wdt_set_a: assert property (watchdog_event && !wdt_reset_enable |=> watchdog_irq || wdt_reset_enable)
    else $error("wdt flag");
endmodule
bind acr_regs acr_regs_chk chk (.*);

/* sim/adc_control_result_regs_bench.sv */
`timescale 1ns/1ps
module adc_control_result_regs_bench;
  logic        ref_clk = 0, rstn = 0, sfr_wr = 0, sfr_rd = 0, conv_done = 0, watchdog_event = 0, cal_start;
  logic        wdt_reset_enable = 0, aux_source_pending = 0, sfr_hit, watchdog_reset, data_irq, aux_irq, watchdog_irq;
  logic        port1_baud_doubler, temp_sensor_on, burnout_current_enable, internal_ref_enable, ref_level_select;
  logic        input_buffer_enable, result_coding_select;
  logic [1:0]  settling_select;
  logic [2:0]  gain_select, calibration_select;
  logic [7:0]  sfr_addr = 0, sfr_wdata = 0, sfr_rdata, input_mux_reg, gain_factor;
  logic [8:0]  neg_input_onehot;
  logic [23:0] conv_sample = 0;
  integer      n_fail = 0, check_count = 0, i;
  acr_regs uut (.*);
  always #5 ref_clk = ~ref_clk;
  task chk(input logic [23:0] seen, exp);
    check_count++;
    n_fail += (seen !== exp);
    if (seen !== exp) $display("FAIL %0t: saw %h want %h", $time, seen, exp);
  endtask
  // read: d is the expected value; inputs move only on falling edges
  task acc(input logic w, input logic [7:0] a, d);
    @(negedge ref_clk);
    {sfr_addr, sfr_wdata, sfr_wr, sfr_rd} = {a, d, w, !w};
    @(negedge ref_clk);
    {sfr_wr, sfr_rd} = 2'b00;
    if (!w) chk(sfr_rdata, d);
  endtask
  // sample is scrambled after the pulse so a late capture shows
  task ev(input logic c, w, input logic [23:0] s);
    @(negedge ref_clk);
    {conv_done, watchdog_event, conv_sample} = {c, w, s};
    @(negedge ref_clk);
    {conv_done, watchdog_event, conv_sample} = {2'b00, ~s};
  endtask
  task summarize(input integer extra);
    n_fail += extra;
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial #100000 summarize(1);
  initial begin
    repeat (10) @(negedge ref_clk);
    rstn = 1;
    acc(0, 8'hD7, 8'h01);
    chk({sfr_hit, input_mux_reg}, 9'h101);
    acc(0, 8'hE0, 8'h00);
    chk(sfr_hit, 0);
    acc(0, 8'hD8, 8'h40);
    acc(0, 8'hDC, 8'h30);
    for (i = 0; i < 9; i++) begin
      acc(1, 8'hD7, {4'hF, i[3:0]});
      chk({temp_sensor_on, neg_input_onehot}, 10'h001 << i);
    end
    acc(1, 8'hD7, 8'hFF);
    chk(temp_sensor_on, 1);
    acc(1, 8'hD8, 8'hB0);
    chk({port1_baud_doubler, aux_irq}, 2'b11);
    acc(1, 8'hD8, 8'h10);
    chk({port1_baud_doubler, aux_irq}, 2'b00);
    ev(0, 1, 0);
    acc(0, 8'hD8, 8'h58);
    aux_source_pending = 1;
    acc(1, 8'hD8, 8'h20);
    chk(aux_irq, 1);
    aux_source_pending = 0;
    acc(1, 8'hD8, 8'h20);
    chk({aux_irq, watchdog_irq}, 2'b00);
    wdt_reset_enable = 1;
    watchdog_event = 1;
    #1 chk(watchdog_reset, 1);
    watchdog_event = 0;
    ev(0, 1, 0);
    chk(watchdog_irq, 0);
    acc(0, 8'hD8, 8'h60);
    ev(1, 0, 24'h80A5C3);
    acc(0, 8'hDB, 8'h80);
    chk(data_irq, 1);
    acc(0, 8'hD9, 8'hC3);
    chk(data_irq, 0);
    for (i = 0; i < 8; i++) begin
      acc(1, 8'hDC, {1'b1, i[0], i[1], !i[0], i[1], i[2:0]});
      acc(0, 8'hDC, {1'b0, i[0], i[1], !i[0], i[1], i[2:0]});
      chk(gain_factor, 8'h01 << i);
      chk({burnout_current_enable, internal_ref_enable, ref_level_select, input_buffer_enable, gain_select},
          {i[0], i[1], !i[0], i[1], i[2:0]});
    end
    for (i = 0; i < 8; i++) begin
      acc(1, 8'hDD, {1'b1, i[0], i[1:0], 1'b0, i[2:0]});
      chk({cal_start, result_coding_select, settling_select}, {i > 0 && i < 6, i[0], i[1:0]});
      chk(calibration_select, (i < 6) ? i[2:0] : 3'h5);
      acc(0, 8'hDD, {1'b0, i[0], i[1:0], 1'b0, i[2:0]});
    end
    ev(1, 0, 24'h800000);
    acc(0, 8'hDB, 8'h00);
    ev(1, 0, 24'h7FFFFF);
    acc(0, 8'hDB, 8'hFF);
    acc(0, 8'hD9, 8'hFF);
    summarize(0);
  end
endmodule

/* src/acr_regs.v */
`timescale 1ns/1ps
`include "acr_map.vh"
module acr_regs (
  input  wire        ref_clk,            // core clock
  input  wire        rstn,               // async reset, active low
  input  wire [7:0]  sfr_addr,           // register address
  input  wire [7:0]  sfr_wdata,          // write data
  input  wire        sfr_wr,             // write strobe
  input  wire        sfr_rd,             // read strobe
  output reg  [7:0]  sfr_rdata,          // read data
  output wire        sfr_hit,            // address is ours
  input  wire        conv_done,          // one-cycle conversion complete
  input  wire [23:0] conv_sample,        // modulator sample, two's complement
  input  wire        aux_source_pending, // any masked aux source pending
  input  wire        watchdog_event,     // watchdog expiry pulse
  input  wire        wdt_reset_enable,   // reset action from hardware_config_zero
  output wire        watchdog_reset,     // watchdog reset request
  output wire        data_irq,           // converter data interrupt
  output wire        aux_irq,            // auxiliary interrupt request
  output wire        watchdog_irq,       // watchdog interrupt request
  output wire        port1_baud_doubler, // serial port 1 double rate
  output reg  [8:0]  neg_input_onehot,   // inputs 0-7, bit 8 common
  output reg         temp_sensor_on,     // temperature sensor connected
  output wire [7:0]  input_mux_reg,      // full mux register
  output wire        burnout_current_enable, // burnout sources on
  output wire        internal_ref_enable,    // reference on
  output wire        ref_level_select,       // 1 = 2.5V
  output wire        input_buffer_enable,    // buffer on
  output wire [2:0]  gain_select,        // gain code
  output wire [7:0]  gain_factor,        // gain value 1..128
  output wire        result_coding_select, // 1 = unipolar
  output wire [1:0]  settling_select,    // filter settling mode
  output reg         cal_start,          // calibration start pulse
  output reg  [2:0]  calibration_select  // calibration code latched at start
);

  localparam [7:0] rst_irq_value = `ACR_RST_IRQ;

  // stored register state
  reg  [7:0]  mux_reg;
  reg         baud_double;
  reg         aux_enable;
  reg         aux_flag;
  reg         wdt_flag;
  reg  [7:0]  analog_front_control;
  reg  [7:0]  coding_filter_cal_control;
  reg  [23:0] result_word;
  reg         data_pend;

  // combinational helpers
  reg  [7:0]  next_rdata;
  reg  [23:0] next_result;
  reg  [23:0] unipolar_code;
  reg  [7:0]  next_gain;
  reg         next_aux_flag;
  reg         next_wdt_flag;
  reg         next_cal_start;
  reg         addr_in_range;

  wire [7:0]  irq_enable_flags;
  wire        wr_mux;
  wire        wr_irq;
  wire        wr_afc;
  wire        wr_cfc;
  wire        rd_low;
  wire        wdt_irq_path;
  wire [2:0]  cal_code_in;

  // one write strobe per writable register, plus a read strobe for the low result byte
  assign wr_mux      = sfr_wr && (sfr_addr == `ACR_ADDR_MUX);
  assign wr_irq      = sfr_wr && (sfr_addr == `ACR_ADDR_IRQ);
  assign wr_afc      = sfr_wr && (sfr_addr == `ACR_ADDR_AFC);
  assign wr_cfc      = sfr_wr && (sfr_addr == `ACR_ADDR_CFC);
  assign rd_low      = sfr_rd && (sfr_addr == `ACR_ADDR_RES_LO);
  assign cal_code_in = sfr_wdata[2:0];

  assign input_mux_reg  = mux_reg;
  assign wdt_irq_path   = !wdt_reset_enable;
  assign watchdog_reset = wdt_reset_enable && watchdog_event;

  always @* begin
    case (sfr_addr)
      `ACR_ADDR_MUX:     addr_in_range = 1'b1;
      `ACR_ADDR_IRQ:     addr_in_range = 1'b1;
      `ACR_ADDR_RES_LO:  addr_in_range = 1'b1;
      `ACR_ADDR_RES_MID: addr_in_range = 1'b1;
      `ACR_ADDR_RES_HI:  addr_in_range = 1'b1;
      `ACR_ADDR_AFC:     addr_in_range = 1'b1;
      `ACR_ADDR_CFC:     addr_in_range = 1'b1;
      default:           addr_in_range = 1'b0;
    endcase
  end
  assign sfr_hit = addr_in_range;

  // multiplexer register
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mux_reg <= `ACR_RST_MUX;
    end else if (wr_mux) begin
      mux_reg <= sfr_wdata;
    end
  end

  // front-end control; bit 7 is unused and reads zero
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      analog_front_control <= `ACR_RST_AFC;
    end else if (wr_afc) begin
      analog_front_control <= {1'b0, sfr_wdata[6:0]};
    end
  end

  // coding, settling and calibration control; bit 7 is unused
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      coding_filter_cal_control <= `ACR_RST_CFC;
    end else if (wr_cfc) begin
      coding_filter_cal_control <= {1'b0, sfr_wdata[6:0]};
    end
  end

  // reserved codes are stored but start nothing
  always @* begin
    next_cal_start = 1'b0;
    if (wr_cfc) begin
      case (cal_code_in)
        3'h1:    next_cal_start = 1'b1;
        3'h2:    next_cal_start = 1'b1;
        3'h3:    next_cal_start = 1'b1;
        3'h4:    next_cal_start = 1'b1;
        3'h5:    next_cal_start = 1'b1;
        default: next_cal_start = 1'b0;
      endcase
    end
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cal_start <= 1'b0;
      calibration_select <= 3'h0;
    end else begin
      cal_start <= next_cal_start;
      if (next_cal_start)
        calibration_select <= cal_code_in;
    end
  end

  // serial doubler and aux enable are plain software bits
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      baud_double <= rst_irq_value[`ACR_BIT_BAUD2];
      aux_enable <= rst_irq_value[`ACR_BIT_AUX_EN];
    end else if (wr_irq) begin
      baud_double <= sfr_wdata[`ACR_BIT_BAUD2];
      aux_enable <= sfr_wdata[`ACR_BIT_AUX_EN];
    end
  end

  // a source still pending re-raises the flag; set wins over a clear
  always @* begin
    next_aux_flag = aux_flag;
    if (aux_source_pending)
      next_aux_flag = 1'b1;
    else if (wr_irq)
      next_aux_flag = sfr_wdata[`ACR_BIT_AUX_FLAG];
  end

  always @* begin
    next_wdt_flag = wdt_flag;
    if (watchdog_event && wdt_irq_path)
      next_wdt_flag = 1'b1;
    else if (wr_irq)
      next_wdt_flag = sfr_wdata[`ACR_BIT_WDT_FLAG];
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      aux_flag <= rst_irq_value[`ACR_BIT_AUX_FLAG];
      wdt_flag <= rst_irq_value[`ACR_BIT_WDT_FLAG];
    end else begin
      aux_flag <= next_aux_flag;
      wdt_flag <= next_wdt_flag;
    end
  end

  // bit 6 reads as one and bits 2-0 as zero
  assign irq_enable_flags   = {baud_double, 1'b1, aux_enable, aux_flag, wdt_flag, 3'h0};
  assign port1_baud_doubler = baud_double;
  assign aux_irq            = aux_enable && aux_flag;
  // no separate watchdog enable here; the path is gated by the reset action
  assign watchdog_irq       = wdt_irq_path && wdt_flag;

  // unipolar: half the lsb size, negatives clamp to zero
  always @* begin
    if (conv_sample[23])
      unipolar_code = 24'h000000;
    else
      unipolar_code = {conv_sample[22:0], conv_sample[22]};
  end

  always @* begin
    if (result_coding_select)
      next_result = unipolar_code;
    else
      next_result = conv_sample;
  end

  // all three bytes load together so a byte-wise read stays coherent
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      result_word <= 24'h000000;
    end else if (conv_done) begin
      result_word <= next_result;
    end
  end

  // a new sample wins over a read clear in the same cycle
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      data_pend <= 1'b0;
    end else if (conv_done) begin
      data_pend <= 1'b1;
    end else if (rd_low) begin
      data_pend <= 1'b0;
    end
  end
  assign data_irq = data_pend;

  // read data registered one cycle after the strobe, held until the next read
  always @* begin
    case (sfr_addr)
      `ACR_ADDR_MUX:     next_rdata = mux_reg;
      `ACR_ADDR_IRQ:     next_rdata = irq_enable_flags;
      `ACR_ADDR_RES_LO:  next_rdata = result_word[7:0];
      `ACR_ADDR_RES_MID: next_rdata = result_word[15:8];
      `ACR_ADDR_RES_HI:  next_rdata = result_word[23:16];
      `ACR_ADDR_AFC:     next_rdata = analog_front_control;
      `ACR_ADDR_CFC:     next_rdata = coding_filter_cal_control;
      default:           next_rdata = 8'h00;
    endcase
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      sfr_rdata <= 8'h00;
    else if (sfr_rd)
      sfr_rdata <= next_rdata;
  end

  // negative input decode; codes 9 to 15 route no input
  always @* begin
    neg_input_onehot = 9'h000;
    temp_sensor_on = (mux_reg == `ACR_MUX_TEMP);
    case (mux_reg[3:0])
      4'h0:    neg_input_onehot = 9'h001;
      4'h1:    neg_input_onehot = 9'h002;
      4'h2:    neg_input_onehot = 9'h004;
      4'h3:    neg_input_onehot = 9'h008;
      4'h4:    neg_input_onehot = 9'h010;
      4'h5:    neg_input_onehot = 9'h020;
      4'h6:    neg_input_onehot = 9'h040;
      4'h7:    neg_input_onehot = 9'h080;
      4'h8:    neg_input_onehot = 9'h100;
      default: neg_input_onehot = 9'h000;
    endcase
  end

  // gain as a value, two to the power of the code
  always @* begin
    case (gain_select)
      3'h0:    next_gain = 8'h01;
      3'h1:    next_gain = 8'h02;
      3'h2:    next_gain = 8'h04;
      3'h3:    next_gain = 8'h08;
      3'h4:    next_gain = 8'h10;
      3'h5:    next_gain = 8'h20;
      3'h6:    next_gain = 8'h40;
      3'h7:    next_gain = 8'h80;
      default: next_gain = 8'h01;
    endcase
  end
  assign gain_factor = next_gain;

  // an open input with burnout on reads full scale; nothing here clamps it
  assign burnout_current_enable = analog_front_control[`ACR_BIT_BURNOUT];
  assign internal_ref_enable    = analog_front_control[`ACR_BIT_REF_EN];
  assign ref_level_select       = analog_front_control[`ACR_BIT_REF_LVL];
  assign input_buffer_enable    = analog_front_control[`ACR_BIT_BUF_EN];
  assign gain_select            = analog_front_control[2:0];
  assign result_coding_select   = coding_filter_cal_control[`ACR_BIT_POL];
  assign settling_select        = coding_filter_cal_control[5:4];

endmodule
